// *** logic/rsc_pin_filter.sv ***
// external reset pin synchroniser and low-level de-bounce filter
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_pin_filter #(
  parameter logic [19:0] DB_LAST = 20'h0_0001
) (
  input logic clk,
  input logic rst_n,
  input logic pin_n,
  output logic low,
  output logic held
);
  logic s1_q;
  logic s2_q;
  logic low_q;
  logic held_q;
  logic [19:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= pin_n;
      s2_q <= s1_q;
    end
  end

  // any high sample restarts the span, so short glitches never reach held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= `RSC_CNT_ZERO;
      held_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      low_q <= !s2_q;
      if (s2_q) begin
        cnt_q <= `RSC_CNT_ZERO;
        held_q <= 1'b0;
      end else if (cnt_q != DB_LAST) begin
        cnt_q <= cnt_q + 20'h0_0001;
      end else begin
        held_q <= 1'b1;
      end
    end
  end

  assign low = low_q;
  assign held = held_q;

  a_filter_span: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(held_q) |-> $past(cnt_q) == DB_LAST && $past(!s2_q))
    else $error("de-bounce released before full low span");
endmodule

// *** logic/rsc_pkg.sv ***
// types shared by the reset source controller
package rsc_pkg;
  typedef enum logic [4:0] {
    RSC_ST_RUN = 5'h01,
    RSC_ST_HOLD = 5'h02,
    RSC_ST_STAB = 5'h04,
    RSC_ST_WARM = 5'h08,
    RSC_ST_SLOW = 5'h10
  } rsc_state_t;
  typedef enum logic [1:0] {
    RSC_WD_DIS = 2'h0,
    RSC_WD_ENA = 2'h1,
    RSC_WD_ALW = 2'h2
  } rsc_wd_mode_t;
  typedef enum logic [1:0] {
    RSC_XR_GPIO = 2'h0,
    RSC_XR_DIRECT = 2'h1,
    RSC_XR_FILTER = 2'h2
  } rsc_xr_mode_t;
  typedef enum logic [1:0] {
    RSC_CPU_NORMAL = 2'h0,
    RSC_CPU_IDLE = 2'h1,
    RSC_CPU_STOP = 2'h2
  } rsc_cpu_mode_t;
  typedef enum logic [2:0] {
    RSC_R_NONE = 3'h0,
    RSC_R_WDCLR = 3'h1,
    RSC_R_CAUSE = 3'h2,
    RSC_R_SOFT = 3'h3,
    RSC_R_OPT = 3'h4
  } rsc_reg_t;
  typedef struct packed {
    logic [2:0] clk_src;
    rsc_wd_mode_t wd_mode;
    logic [1:0] wd_div;
    rsc_xr_mode_t xr_mode;
  } rsc_opt_t;
endpackage

// *** logic/rsc_regs.svh ***
// register map, field positions, reset values and timing counts
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
`define RSC_IDX_WDCLR 10'h086
`define RSC_IDX_CAUSE 10'h090
`define RSC_IDX_SOFT 10'h091
`define RSC_IDX_OPT 10'h092
`define RSC_WD_MAGIC 8'h5A
`define RSC_WD_LAST 8'hFF
`define RSC_WD_ZERO 8'h00
`define RSC_PRE_ZERO 5'h00
`define RSC_PRE_LAST_4 5'h03
`define RSC_PRE_LAST_8 5'h07
`define RSC_PRE_LAST_16 5'h0F
`define RSC_PRE_LAST_32 5'h1F
`define RSC_BIT_LVD 7
`define RSC_BIT_WDT 6
`define RSC_BIT_EXT 5
`define RSC_BIT_SOFT 0
`define RSC_CAUSE_LVD 3'h4
`define RSC_CAUSE_WDT 3'h2
`define RSC_CAUSE_EXT 3'h1
`define RSC_CAUSE_NONE 3'h0
`define RSC_OPT_RST 9'h000
`define RSC_DATA_ZERO 32'h0000_0000
`define RSC_CNT_ZERO 20'h0_0000
`define RSC_WARM_LAST 20'h0_07FF
`define RSC_SLOW_LAST 3'h4
`define RSC_SLOW_ZERO 3'h0
`define RSC_CLK_PERIOD_NS 8
`define RSC_STAB_TIME_NS 4600000
`define RSC_DB_TIME_NS 8000000
`endif

// *** logic/rsc_top.sv ***
// reset source controller: watchdog, reset pin, soft reset, cause flags
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_top
  import rsc_pkg::*;
#(
  parameter int STAB_CYCLES = (`RSC_STAB_TIME_NS + `RSC_CLK_PERIOD_NS - 1)
                              / `RSC_CLK_PERIOD_NS,
  parameter int DB_CYCLES = (`RSC_DB_TIME_NS + `RSC_CLK_PERIOD_NS - 1)
                            / `RSC_CLK_PERIOD_NS
) (
  input logic CORE_CLK,
  input logic RST_N,
  input logic [11:0] PADDR,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input rsc_opt_t OPTIONS,
  input rsc_cpu_mode_t CPU_MODE,
  input logic SLOW_OSC,
  input logic LOW_VOLT_DET,
  input logic EXT_RST_N,
  output logic SYS_RST_N,
  output logic CLK_SRC_EN,
  output logic [2:0] CLK_SRC_SEL
);
  rsc_state_t state_q;
  rsc_state_t state_d;
  rsc_opt_t opt_q;
  logic [19:0] cnt_q;
  logic [2:0] slow_q;
  logic seq_q;
  logic sys_rst_n_q;
  logic clk_en_q;
  logic [2:0] cause_q;
  logic soft_q;
  logic pend_q;
  logic sw_fire_q;
  logic [4:0] pre_q;
  logic [7:0] wd_q;
  logic wd_exp_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic lvd_s1_q;
  logic lvd_s2_q;
  logic xr_low;
  logic xr_held;
  logic ext_req;
  logic slow_tick;
  logic cnt_en;
  logic acc;
  logic wr;
  logic wd_clr;
  logic soft_wr;
  logic src_active;
  rsc_reg_t sel;

  function automatic rsc_reg_t reg_decode(input logic [11:0] addr);
    if (addr[1:0] != 2'h0) begin
      reg_decode = RSC_R_NONE;
    end else if (addr[11:2] == `RSC_IDX_WDCLR) begin
      reg_decode = RSC_R_WDCLR;
    end else if (addr[11:2] == `RSC_IDX_CAUSE) begin
      reg_decode = RSC_R_CAUSE;
    end else if (addr[11:2] == `RSC_IDX_SOFT) begin
      reg_decode = RSC_R_SOFT;
    end else if (addr[11:2] == `RSC_IDX_OPT) begin
      reg_decode = RSC_R_OPT;
    end else begin
      reg_decode = RSC_R_NONE;
    end
  endfunction

  function automatic logic [4:0] pre_last(input logic [1:0] div);
    case (div)
      2'h0: pre_last = `RSC_PRE_LAST_4;
      2'h1: pre_last = `RSC_PRE_LAST_8;
      2'h2: pre_last = `RSC_PRE_LAST_16;
      default: pre_last = `RSC_PRE_LAST_32;
    endcase
  endfunction

  // pins and the slow oscillator come from outside this clock domain
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      lvd_s1_q <= 1'b0;
      lvd_s2_q <= 1'b0;
    end else begin
      osc_s1_q <= SLOW_OSC;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      lvd_s1_q <= LOW_VOLT_DET;
      lvd_s2_q <= lvd_s1_q;
    end
  end

  assign slow_tick = osc_s2_q && !osc_s3_q;

  rsc_pin_filter #(
    .DB_LAST(20'(DB_CYCLES - 1))
  ) u_pin (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin_n(EXT_RST_N),
    .low(xr_low),
    .held(xr_held)
  );

  assign ext_req = (opt_q.xr_mode == RSC_XR_DIRECT && xr_low) ||
                   (opt_q.xr_mode == RSC_XR_FILTER && xr_held);
  assign src_active = lvd_s2_q || ext_req;

  // apb: answer in the cycle after setup, no further wait states
  assign sel = reg_decode(PADDR);
  assign acc = PSEL && PENABLE && pready_q;
  assign wr = acc && PWRITE;
  assign wd_clr = wr && sel == RSC_R_WDCLR &&
                  PWDATA[7:0] == `RSC_WD_MAGIC;
  assign soft_wr = wr && sel == RSC_R_SOFT;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `RSC_DATA_ZERO;
    end else begin
      pready_q <= PSEL && !PENABLE;
      if (PSEL && !PENABLE) begin
        pslverr_q <= sel == RSC_R_NONE;
        prdata_q <= `RSC_DATA_ZERO;
        if (!PWRITE && sel == RSC_R_CAUSE) begin
          prdata_q[`RSC_BIT_LVD] <= cause_q[2];
          prdata_q[`RSC_BIT_WDT] <= cause_q[1];
          prdata_q[`RSC_BIT_EXT] <= cause_q[0];
        end else if (!PWRITE && sel == RSC_R_SOFT) begin
          prdata_q[`RSC_BIT_SOFT] <= soft_q;
        end else if (!PWRITE && sel == RSC_R_OPT) begin
          prdata_q[8:0] <= opt_q;
        end
      end else if (acc) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // a first write stays pending across unrelated accesses
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pend_q <= 1'b0;
      sw_fire_q <= 1'b0;
    end else begin
      sw_fire_q <= 1'b0;
      if (state_q != RSC_ST_RUN) begin
        pend_q <= 1'b0;
      end else if (soft_wr && PWDATA[`RSC_BIT_SOFT] && pend_q) begin
        pend_q <= 1'b0;
        sw_fire_q <= 1'b1;
      end else if (soft_wr && PWDATA[`RSC_BIT_SOFT]) begin
        pend_q <= 1'b1;
      end else if (soft_wr) begin
        pend_q <= 1'b0;
      end
    end
  end

  // stop mode still sees the slow oscillator, so always mode keeps going
  always_comb begin
    cnt_en = 1'b0;
    if (state_q == RSC_ST_RUN && slow_tick) begin
      case (opt_q.wd_mode)
        RSC_WD_ALW: cnt_en = 1'b1;
        RSC_WD_ENA: cnt_en = CPU_MODE == RSC_CPU_NORMAL;
        default: cnt_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pre_q <= `RSC_PRE_ZERO;
      wd_q <= `RSC_WD_ZERO;
      wd_exp_q <= 1'b0;
    end else begin
      wd_exp_q <= 1'b0;
      if (state_q != RSC_ST_RUN || wd_clr) begin
        pre_q <= `RSC_PRE_ZERO;
        wd_q <= `RSC_WD_ZERO;
      end else if (cnt_en && pre_q == pre_last(opt_q.wd_div)) begin
        pre_q <= `RSC_PRE_ZERO;
        wd_q <= wd_q + 8'h01;
        wd_exp_q <= wd_q == `RSC_WD_LAST;
      end else if (cnt_en) begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      RSC_ST_RUN: begin
        if (src_active || wd_exp_q || sw_fire_q) begin
          state_d = RSC_ST_HOLD;
        end
      end
      RSC_ST_HOLD: begin
        if (src_active) begin
          state_d = RSC_ST_HOLD;
        end else if (seq_q) begin
          state_d = RSC_ST_STAB;
        end else begin
          state_d = RSC_ST_RUN;
        end
      end
      RSC_ST_STAB: begin
        if (src_active) begin
          state_d = RSC_ST_HOLD;
        end else if (cnt_q == 20'(STAB_CYCLES - 1)) begin
          state_d = RSC_ST_WARM;
        end
      end
      RSC_ST_WARM: begin
        if (src_active) begin
          state_d = RSC_ST_HOLD;
        end else if (cnt_q == `RSC_WARM_LAST) begin
          state_d = RSC_ST_SLOW;
        end
      end
      RSC_ST_SLOW: begin
        if (src_active) begin
          state_d = RSC_ST_HOLD;
        end else if (slow_tick && slow_q == `RSC_SLOW_LAST) begin
          state_d = RSC_ST_RUN;
        end
      end
      default: state_d = RSC_ST_HOLD;
    endcase
  end

  // power-on takes the same path as a low-voltage reset
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= RSC_ST_STAB;
      cnt_q <= `RSC_CNT_ZERO;
      slow_q <= `RSC_SLOW_ZERO;
      sys_rst_n_q <= 1'b0;
      clk_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sys_rst_n_q <= state_d == RSC_ST_RUN;
      clk_en_q <= state_d == RSC_ST_WARM || state_d == RSC_ST_SLOW ||
                  (state_d == RSC_ST_RUN && clk_en_q);
      if (state_d != state_q) begin
        cnt_q <= `RSC_CNT_ZERO;
        slow_q <= `RSC_SLOW_ZERO;
      end else begin
        cnt_q <= cnt_q + 20'h0_0001;
        if (slow_tick) begin
          slow_q <= slow_q + 3'h1;
        end
      end
    end
  end

  // options are taken each time the power-stable wait ends and stay fixed until the next full sequence
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      opt_q <= `RSC_OPT_RST;
    end else if (state_q == RSC_ST_STAB && state_d == RSC_ST_WARM) begin
      opt_q <= OPTIONS;
    end
  end

  // cause flags survive the system reset they describe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cause_q <= `RSC_CAUSE_LVD;
      soft_q <= 1'b0;
      seq_q <= 1'b1;
    end else if (state_q == RSC_ST_RUN && state_d == RSC_ST_HOLD) begin
      soft_q <= 1'b0;
      seq_q <= 1'b1;
      if (lvd_s2_q) begin
        cause_q <= `RSC_CAUSE_LVD;
      end else if (wd_exp_q) begin
        cause_q <= `RSC_CAUSE_WDT;
      end else if (ext_req) begin
        cause_q <= `RSC_CAUSE_EXT;
      end else begin
        cause_q <= `RSC_CAUSE_NONE;
        soft_q <= 1'b1;
        seq_q <= 1'b0;
      end
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign SYS_RST_N = sys_rst_n_q;
  assign CLK_SRC_EN = clk_en_q;
  assign CLK_SRC_SEL = opt_q.clk_src;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_wd_magic_clear: assert property (
    wd_clr |=> wd_q == `RSC_WD_ZERO && pre_q == `RSC_PRE_ZERO)
    else $error("magic write did not clear watchdog");
  a_wd_expiry: assert property (
    wd_exp_q |-> $past(wd_q) == `RSC_WD_LAST && $past(cnt_en))
    else $error("watchdog expired before 256 prescaled ticks");
  a_wd_always_runs: assert property (
    state_q == RSC_ST_RUN && opt_q.wd_mode == RSC_WD_ALW && slow_tick
    |-> cnt_en)
    else $error("always mode watchdog did not count");
  a_wd_enable_sleep: assert property (
    opt_q.wd_mode == RSC_WD_ENA && CPU_MODE != RSC_CPU_NORMAL
    |-> !cnt_en ##1 !wd_exp_q)
    else $error("enable mode watchdog counted while asleep");
  a_wd_disabled: assert property (
    opt_q.wd_mode == RSC_WD_DIS && $past(opt_q.wd_mode) == RSC_WD_DIS
    |-> !cnt_en && !wd_exp_q)
    else $error("disabled watchdog moved");
  a_ext_direct: assert property (
    state_q == RSC_ST_RUN && opt_q.xr_mode == RSC_XR_DIRECT && xr_low
    |=> !SYS_RST_N && state_q == RSC_ST_HOLD)
    else $error("direct pin low did not reset at once");
  a_ext_filter: assert property (
    opt_q.xr_mode == RSC_XR_FILTER && !xr_held |-> !ext_req)
    else $error("filtered pin reset before de-bounce span");
  a_soft_two_writes: assert property (
    sw_fire_q |-> $past(pend_q) && $past(soft_wr))
    else $error("soft reset without a pending first write");
  a_soft_flag: assert property (
    state_q == RSC_ST_RUN && sw_fire_q && !src_active && !wd_exp_q
    |=> soft_q && state_q == RSC_ST_HOLD)
    else $error("soft reset flag not set");
  a_cause_wdt: assert property (
    state_q == RSC_ST_RUN && wd_exp_q && !src_active
    |=> cause_q == `RSC_CAUSE_WDT)
    else $error("watchdog cause flag wrong");
  a_soft_no_seq: assert property (
    state_q == RSC_ST_HOLD && !seq_q && !src_active
    |=> state_q == RSC_ST_RUN ##1 SYS_RST_N)
    else $error("soft reset ran the power-on sequence");
  a_warm_length: assert property (
    state_q == RSC_ST_WARM && state_d == RSC_ST_SLOW
    |-> cnt_q == `RSC_WARM_LAST)
    else $error("warm-up shorter than 2048 clocks");
  a_reserved_zero: assert property (
    PREADY && !PWRITE && PSEL && sel == RSC_R_SOFT
    |-> PRDATA[31:1] == 31'h0000_0000)
    else $error("reserved soft bits read nonzero");
  a_cancel_pend: assert property (
    soft_wr && !PWDATA[`RSC_BIT_SOFT] |=> !pend_q && !sw_fire_q)
    else $error("other value did not cancel request");

  c_soft_reset: cover property (sw_fire_q ##1 state_q == RSC_ST_HOLD);
  c_wd_reset: cover property (wd_exp_q && state_q == RSC_ST_RUN);
  c_ext_reset: cover property (state_q == RSC_ST_RUN && ext_req);
  c_full_seq: cover property (state_q == RSC_ST_SLOW ##1
                              state_q == RSC_ST_RUN);
endmodule

// *** verif/rsc_pin_model.sv ***
// board-side model of the external reset pin with its pull-up
`timescale 1ns/1ps
module rsc_pin_model (
  input wire logic clk,
  output logic pin_n
);
  // a released pin is pulled up, so idle reads high
  initial pin_n = 1'b1;
  task automatic press(input int cycles);
    pin_n <= 1'b0;
    repeat (cycles) @(posedge clk);
    pin_n <= 1'b1;
  endtask
endmodule

// *** verif/rsc_top_tb.sv ***
// self-checking bench for the reset source controller
`timescale 1ns/1ps
`include "rsc_regs.svh"
module rsc_top_tb;
  import rsc_pkg::*;
  localparam int STAB = 20;
  localparam int DB = 10;
  logic CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  rsc_opt_t OPTIONS;
  rsc_cpu_mode_t CPU_MODE;
  logic SLOW_OSC, LOW_VOLT_DET, EXT_RST_N, SYS_RST_N, CLK_SRC_EN;
  logic [2:0] CLK_SRC_SEL;
  logic [32:0] exp_q[$];
  int bad_count, cmp_count, seed, ticks, n, t0;
  rsc_top #(.STAB_CYCLES(STAB), .DB_CYCLES(DB)) dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OPTIONS(OPTIONS), .CPU_MODE(CPU_MODE), .SLOW_OSC(SLOW_OSC),
    .LOW_VOLT_DET(LOW_VOLT_DET), .EXT_RST_N(EXT_RST_N),
    .SYS_RST_N(SYS_RST_N), .CLK_SRC_EN(CLK_SRC_EN),
    .CLK_SRC_SEL(CLK_SRC_SEL)
  );
  rsc_pin_model pin (.clk(CORE_CLK), .pin_n(EXT_RST_N));
  initial begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  // slow source at an eighth of the core rate, unrelated in phase
  initial begin
    SLOW_OSC = 1'b0;
    #3;
    forever #32 SLOW_OSC = ~SLOW_OSC;
  end
  always @(posedge SLOW_OSC) ticks <= ticks + 1;
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ok(input logic c);
    check({32'h0, c}, 33'h1);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches %0d", s, bad_count);
  endtask
  // each completed transfer is matched against the oldest note
  always @(posedge CORE_CLK) begin
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1) begin
      check({PSLVERR, PWRITE ? 32'h0 : PRDATA}, exp_q.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int k = 0;
    exp_q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle edge keeps the next call from driving in this time step
    @(posedge CORE_CLK);
    if (k >= 20) begin
      ok(1'b0);
      results();
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, {24'h0, d}, 33'h0);
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0, {1'b0, e});
  endtask
  task automatic wsys(input logic v, input int max);
    n = 0;
    while (SYS_RST_N !== v && n < max) begin
      @(posedge CORE_CLK);
      n++;
    end
    if (SYS_RST_N !== v) begin
      check({32'h0, SYS_RST_N}, {32'h0, v});
      results();
    end
  endtask
  task automatic twait(input int t);
    repeat (t) @(posedge SLOW_OSC);
    @(posedge CORE_CLK);
  endtask
  task automatic por(input rsc_wd_mode_t m, input rsc_xr_mode_t x);
    rsc_opt_t o;
    o = '{clk_src: 3'($random(seed)), wd_mode: m, wd_div: 2'h0,
          xr_mode: x};
    OPTIONS <= o;
    RST_N <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    wsys(1'b1, 3000);
    ok(n >= STAB + 2048 && n <= STAB + 2048 + 80);
    ok(CLK_SRC_SEL === o.clk_src && CLK_SRC_EN === 1'b1);
    rd(`RSC_IDX_OPT, {23'h00_0000, o});
    rd(`RSC_IDX_CAUSE, 32'h0000_0080);
  endtask
  initial begin
    seed = 41;
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    LOW_VOLT_DET = 1'b0;
    CPU_MODE = RSC_CPU_NORMAL;
    OPTIONS = '0;
    @(posedge CORE_CLK);
    por(RSC_WD_ALW, RSC_XR_DIRECT);
    rd(`RSC_IDX_SOFT, 32'h0000_0000);
    apb(1'b0, 12'hFFC, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h241, 32'h1, {1'b1, 32'h0});
    wr(`RSC_IDX_CAUSE, 8'($random(seed)));
    rd(`RSC_IDX_CAUSE, 32'h0000_0080);
    rd(`RSC_IDX_WDCLR, 32'h0000_0000);
    done("registers");
    wr(`RSC_IDX_SOFT, 8'h01);
    wr(`RSC_IDX_SOFT, 8'hFE);
    wr(`RSC_IDX_SOFT, 8'h01);
    repeat (4) @(posedge CORE_CLK);
    ok(SYS_RST_N === 1'b1);
    wr(`RSC_IDX_SOFT, 8'h01);
    wsys(1'b0, 5);
    wsys(1'b1, 4);
    rd(`RSC_IDX_SOFT, 32'h0000_0001);
    rd(`RSC_IDX_CAUSE, 32'h0000_0000);
    done("soft reset");
    CPU_MODE <= RSC_CPU_STOP;
    repeat (3) begin
      twait(600);
      wr(`RSC_IDX_WDCLR, `RSC_WD_MAGIC);
      ok(SYS_RST_N === 1'b1);
    end
    t0 = ticks;
    twait(500);
    // values below 90 never hit the clear code
    wr(`RSC_IDX_WDCLR, 8'({$random(seed)} % 90));
    wsys(1'b0, 8400);
    ok(ticks - t0 >= 1021 && ticks - t0 <= 1027);
    wsys(1'b1, 3000);
    rd(`RSC_IDX_CAUSE, 32'h0000_0040);
    done("watchdog always");
    fork
      pin.press(100);
    join_none
    wsys(1'b0, 6);
    repeat (50) @(posedge CORE_CLK);
    ok(SYS_RST_N === 1'b0);
    wsys(1'b1, 3000);
    ok(n >= 40 + STAB + 2048);
    rd(`RSC_IDX_CAUSE, 32'h0000_0020);
    done("direct pin");
    CPU_MODE <= RSC_CPU_IDLE;
    por(RSC_WD_ENA, RSC_XR_FILTER);
    fork
      pin.press(DB - 4);
    join_none
    repeat (30) @(posedge CORE_CLK);
    ok(SYS_RST_N === 1'b1);
    twait(1100);
    ok(SYS_RST_N === 1'b1);
    CPU_MODE <= RSC_CPU_NORMAL;
    wsys(1'b0, 8400);
    wsys(1'b1, 3000);
    rd(`RSC_IDX_CAUSE, 32'h0000_0040);
    fork
      pin.press(DB + 20);
    join_none
    wsys(1'b0, DB + 8);
    ok(n >= DB);
    wsys(1'b1, 3000);
    rd(`RSC_IDX_CAUSE, 32'h0000_0020);
    done("filtered pin and enabled watchdog");
    por(RSC_WD_DIS, RSC_XR_GPIO);
    twait(1100);
    ok(SYS_RST_N === 1'b1);
    LOW_VOLT_DET <= 1'b1;
    wsys(1'b0, 6);
    repeat (10) @(posedge CORE_CLK);
    LOW_VOLT_DET <= 1'b0;
    wsys(1'b1, 3000);
    ok(n >= STAB + 2048);
    rd(`RSC_IDX_CAUSE, 32'h0000_0080);
    done("disabled watchdog and low voltage");
    results();
  end
  // a hang anywhere ends the run as a mismatch
  initial begin
    repeat (100000) @(posedge CORE_CLK);
    ok(1'b0);
    results();
  end
endmodule
